/* File: src/sls_top.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sls_defs.svh"
// Contract
// - Reinitialise as for init, then flat 32-bit protected mode, paging off.
// - Code selector 8h read-only, stack selector 10h read/write; base 0, limit 4G.
// - The four data segments stay 16-bit real-mode segments.
// - Clear general registers except operand, identification and stack pointer.
// - Keep caches and control registers; clear extended features and protection MSRs.
// - Set debug-disable, init-redirect and A20-mask-disable flags to one.
// - Block base is operand with bits 15:0 cleared, written back.
// - Enable guard blocking device access to the 64 KiB block.
// - Multiprocessor handshake after the guard, before sending the image.
// - Read the image and send it with launch-only transactions.
// - After the transfer, tell the module to finish hash and check.
// - Clear the global interrupt gate so loader code runs atomically.
// - Shutdown while the gate is clear restarts only on hardware reset.
// - Stack pointer becomes block base plus 65536.
// - Jump to block base plus the 16-bit entry offset.
// - No wait for a verdict; the loader always starts.
// - No breakpoint or single-step traps during the launch.
// - Interrupts stay pending until software sets the gate.
// - Hardware debug off during launch; clearing debug-disable re-enables it.
module sls_top (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Avalon-MM register slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Image memory read port
	output sls_pkg::sls_mem_t o_mem,
	input wire logic i_mem_valid,
	input wire logic [31:0] i_mem_rdata,
	// Trusted module stream through the I/O hub
	output sls_pkg::sls_tpm_t o_tpm,
	input wire logic i_tpm_ready,
	// Interprocessor handshake pins
	output logic o_ipi_req,
	input wire logic i_ipi_ack,
	// Interrupt and shutdown pins
	input wire logic [3:0] i_irq,
	input wire logic i_shutdown,
	output logic [3:0] o_irq_deliver,
	// Processor state outputs
	output sls_pkg::sls_arch_t o_arch,
	output logic [31:0] o_operand,
	output logic [31:0] o_stack_ptr,
	output logic [31:0] o_entry_addr,
	output logic o_jump,
	output logic o_guard_en,
	output logic [31:0] o_guard_base,
	output logic o_gate,
	output logic o_trap_block,
	output logic o_debug_en,
	output logic o_halted
);
	import sls_pkg::*;

	sls_regs_t s_reg;
	sls_regs_t s_next;

	// Register read decode, shared by the bus answer and nothing else wide
	function automatic logic [31:0] reg_read(input logic [7:0] a, input sls_regs_t r);
		logic busy;
		busy = (r.st != SLS_IDLE);
		case ({a[7:2], 2'b00})
			`SLS_OFF_CTRL: reg_read = {30'h0, r.mp_en, 1'b0};
			`SLS_OFF_STATUS: reg_read = {24'h0, r.st, r.halted, r.guard_en, r.gate, busy};
			`SLS_OFF_OPERAND: reg_read = r.operand;
			`SLS_OFF_STACK: reg_read = r.stack_pointer_register;
			`SLS_OFF_ENTRY: reg_read = r.eip;
			`SLS_OFF_VMCR: reg_read = {29'h0, r.vmcr};
			`SLS_OFF_PEND: reg_read = {28'h0, r.pend};
			default: reg_read = 32'h00000000;
		endcase
	endfunction : reg_read

	// Word address inside the block
	function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [14:0] i);
		word_addr = base + {15'h0, i, 2'b00};
	endfunction : word_addr

	logic bus_req;
	logic bus_wr;
	logic [16:0] len_round;
	assign bus_req = i_avs_read | i_avs_write;
	// Write lands only on the edge where the master sees waitrequest low
	assign bus_wr = i_avs_write & ~s_reg.wait_reg;
	// Image length in whole words, rounded up
	assign len_round = {1'b0, i_mem_rdata[31:16]} + 17'h00003;

	// Next-state logic for the whole block
	always_comb begin
		s_next = s_reg;
		s_next.jump = 1'b0;
		s_next.arch.gpr_clear = 1'b0;
		s_next.arch.extended_features_register_clear = 1'b0;
		s_next.arch.prot_msr_clear = 1'b0;
		s_next.deliver = 4'h0;

		// Two-flop synchronisers for pins
		s_next.irq_s1 = i_irq;
		s_next.irq_s2 = s_reg.irq_s1;
		s_next.ack_s = {s_reg.ack_s[0], i_ipi_ack};
		s_next.shut_s = {s_reg.shut_s[0], i_shutdown};

		// One wait cycle per access, then the answer
		s_next.wait_reg = ~(bus_req & s_reg.wait_reg);
		if (bus_req & s_reg.wait_reg) begin
			s_next.rdata = reg_read(i_avs_address, s_reg);
		end

		// Pending lanes: a new request wins over delivery in the same cycle
		if (s_reg.gate && s_reg.st == SLS_IDLE) begin
			s_next.deliver = s_reg.pend;
			s_next.pend = s_reg.irq_s2;
		end else begin
			s_next.pend = s_reg.pend | s_reg.irq_s2;
		end

		// Software register writes
		if (bus_wr) begin
			case ({i_avs_address[7:2], 2'b00})
				`SLS_OFF_CTRL: begin
					s_next.mp_en = i_avs_writedata[`SLS_CTRL_MP_EN];
					if (i_avs_writedata[`SLS_CTRL_GATE_SET]) begin
						s_next.gate = 1'b1;
					end
					if (i_avs_writedata[`SLS_CTRL_START] && s_reg.st == SLS_IDLE
						&& !s_reg.halted) begin
						s_next.st = SLS_REINIT;
						s_next.done = 1'b0;
						s_next.trap_block = 1'b1;
					end
				end
				`SLS_OFF_OPERAND: begin
					if (s_reg.st == SLS_IDLE) begin
						s_next.operand = i_avs_writedata;
					end
				end
				`SLS_OFF_VMCR: begin
					// Clearing debug-disable here brings the debug features back
					s_next.vmcr = i_avs_writedata[2:0];
				end
				default: begin
				end
			endcase
		end

		// Shutdown with the gate clear is terminal until reset
		if (s_reg.shut_s[1] && !s_reg.gate) begin
			s_next.halted = 1'b1;
		end

		// Launch sequence, one step after another
		case (s_reg.st)
			SLS_IDLE: begin
			end
			SLS_REINIT: begin
				s_next.arch.prot_mode = 1'b1;
				s_next.arch.paging_en = 1'b0;
				s_next.arch.cs_sel = `SLS_CS_SELECTOR;
				s_next.arch.ss_sel = `SLS_SS_SELECTOR;
				s_next.arch.cs_readonly = 1'b1;
				s_next.arch.ss_rw_expand_up = 1'b1;
				s_next.arch.seg_base = `SLS_SEG_BASE;
				s_next.arch.seg_limit = `SLS_SEG_LIMIT;
				s_next.arch.data_seg_real16 = 1'b1;
				s_next.arch.gpr_clear = 1'b1;
				s_next.arch.extended_features_register_clear = 1'b1;
				s_next.arch.prot_msr_clear = 1'b1;
				s_next.vmcr = `SLS_VMCR_ALL_SET;
				s_next.st = SLS_GUARD;
			end
			SLS_GUARD: begin
				s_next.operand = s_reg.operand & `SLS_BLOCK_MASK;
				s_next.guard_en = 1'b1;
				s_next.idx = 15'h0000;
				s_next.nwords = 15'h0001;
				s_next.ipi_req = s_reg.mp_en;
				s_next.st = s_reg.mp_en ? SLS_SHAKE : SLS_FETCH;
			end
			SLS_SHAKE: begin
				// Wait for the other processors before any image leaves
				if (s_reg.ack_s[1]) begin
					s_next.ipi_req = 1'b0;
					s_next.st = SLS_FETCH;
				end
			end
			SLS_FETCH: begin
				s_next.mem.rd = 1'b1;
				s_next.mem.addr = word_addr(s_reg.operand, s_reg.idx);
				if (s_reg.mem.rd && i_mem_valid) begin
					s_next.mem.rd = 1'b0;
					if (s_reg.idx == 15'h0000) begin
						s_next.entry = i_mem_rdata[15:0];
						// Header word is always sent, even for a zero length
						if (len_round[16:2] != 15'h0000) begin
							s_next.nwords = len_round[16:2];
						end
					end
					s_next.tpm.valid = 1'b1;
					s_next.tpm.kind = SLS_TK_IMAGE;
					s_next.tpm.data = i_mem_rdata;
					s_next.st = SLS_SEND;
				end
			end
			SLS_SEND: begin
				if (i_tpm_ready) begin
					s_next.idx = s_reg.idx + 15'h0001;
					if (s_reg.idx + 15'h0001 == s_reg.nwords) begin
						s_next.tpm.kind = SLS_TK_HASH_END;
						s_next.tpm.data = `SLS_RST_WORD;
						s_next.st = SLS_HASH;
					end else begin
						s_next.tpm.valid = 1'b0;
						s_next.tpm.kind = SLS_TK_NONE;
						s_next.st = SLS_FETCH;
					end
				end
			end
			SLS_HASH: begin
				// Only the hub's acceptance is awaited, never a verdict
				if (i_tpm_ready) begin
					s_next.tpm.valid = 1'b0;
					s_next.tpm.kind = SLS_TK_NONE;
					s_next.st = SLS_MASK;
				end
			end
			SLS_MASK: begin
				s_next.gate = 1'b0;
				s_next.st = SLS_STACK;
			end
			SLS_STACK: begin
				s_next.stack_pointer_register = s_reg.operand + `SLS_BLOCK_SIZE;
				s_next.st = SLS_JUMP;
			end
			SLS_JUMP: begin
				s_next.eip = s_reg.operand + {16'h0000, s_reg.entry};
				s_next.jump = 1'b1;
				s_next.done = 1'b1;
				s_next.trap_block = 1'b0;
				s_next.st = SLS_IDLE;
			end
			default: begin
				s_next.st = SLS_IDLE;
			end
		endcase

		// Debug enable has its own flop, updated on the same edge as the flag
		s_next.debug_en = ~s_next.vmcr[`SLS_VMCR_DEBUG_DISABLE];
	end

	// State register; reset loads constants only
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
			s_reg.st <= SLS_IDLE;
			s_reg.wait_reg <= 1'b1;
			s_reg.gate <= `SLS_RST_GATE;
			s_reg.debug_en <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state flops
	assign o_avs_readdata = s_reg.rdata;
	assign o_avs_waitrequest = s_reg.wait_reg;
	assign o_mem = s_reg.mem;
	assign o_tpm = s_reg.tpm;
	assign o_ipi_req = s_reg.ipi_req;
	assign o_irq_deliver = s_reg.deliver;
	assign o_arch = s_reg.arch;
	assign o_operand = s_reg.operand;
	assign o_stack_ptr = s_reg.stack_pointer_register;
	assign o_entry_addr = s_reg.eip;
	assign o_jump = s_reg.jump;
	assign o_guard_en = s_reg.guard_en;
	assign o_guard_base = s_reg.operand;
	assign o_gate = s_reg.gate;
	assign o_trap_block = s_reg.trap_block;
	// Debug features follow the inverted debug-disable flag
	assign o_debug_en = s_reg.debug_en;
	assign o_halted = s_reg.halted;

	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	chk_reinit_first: assert property (
		s_reg.st == SLS_REINIT |=> s_reg.arch.prot_mode && !s_reg.arch.paging_en
			&& s_reg.st == SLS_GUARD)
		else $error("reinit did not reach flat protected mode before guard");

	chk_segment_load: assert property (
		s_reg.st == SLS_GUARD |-> s_reg.arch.cs_sel == 16'h0008
			&& s_reg.arch.ss_sel == 16'h0010 && s_reg.arch.seg_limit == 32'hFFFFFFFF)
		else $error("segment selectors or limit wrong after reinit");

	chk_vmcr_set: assert property (
		s_reg.st == SLS_REINIT |=> s_reg.vmcr == 3'h7 && !o_debug_en)
		else $error("control flags not all set by launch");

	chk_base_align: assert property (
		s_reg.st == SLS_GUARD |=> s_reg.operand[15:0] == 16'h0000
			&& s_reg.operand[31:16] == $past(s_reg.operand[31:16]) && s_reg.guard_en)
		else $error("block base not aligned or guard off");

	chk_shake_gate: assert property (
		s_reg.st == SLS_SHAKE && !s_reg.ack_s[1] |=> s_reg.st == SLS_SHAKE
			&& !s_reg.tpm.valid)
		else $error("image left before handshake completed");

	chk_hash_after: assert property (
		s_reg.st == SLS_SEND && i_tpm_ready && s_reg.idx + 15'h0001 == s_reg.nwords
			|=> s_reg.tpm.valid && s_reg.tpm.kind == SLS_TK_HASH_END)
		else $error("hash end not sent after last image word");

	chk_no_verdict: assert property (
		s_reg.st == SLS_HASH && i_tpm_ready |-> ##4 s_reg.jump && s_reg.st == SLS_IDLE)
		else $error("loader start not unconditional after hash end");

	chk_gate_mask: assert property (
		s_reg.st == SLS_MASK |=> !s_reg.gate [*2])
		else $error("gate not cleared before stack and jump");

	chk_stack_top: assert property (
		s_reg.st == SLS_STACK |=> s_reg.stack_pointer_register == s_reg.operand + 32'h00010000)
		else $error("stack pointer not one past block end");

	chk_entry_jump: assert property (
		s_reg.jump |-> s_reg.eip == s_reg.operand + {16'h0000, s_reg.entry})
		else $error("jump address not base plus entry");

	chk_hold_irq: assert property (
		!s_reg.gate |=> s_reg.deliver == 4'h0 && (s_reg.pend & $past(s_reg.pend))
			== $past(s_reg.pend))
		else $error("interrupt delivered or lost while gate clear");

	chk_trap_block: assert property (
		s_reg.st != SLS_IDLE && $past(s_reg.st) != SLS_IDLE |-> s_reg.trap_block)
		else $error("traps not blocked during launch");

	chk_halt_stick: assert property (
		s_reg.halted |=> s_reg.halted && s_reg.st != SLS_REINIT)
		else $error("halted processor restarted without reset");

	cov_single_launch: cover property (
		s_reg.st == SLS_GUARD && !s_reg.mp_en ##[1:200] s_reg.jump);
	cov_mp_launch: cover property (s_reg.st == SLS_SHAKE ##[1:200] s_reg.jump);
	cov_held_irq: cover property (!s_reg.gate && s_reg.pend != 4'h0 ##[1:50] s_reg.deliver != 4'h0);
	cov_shutdown: cover property (s_reg.shut_s[1] && !s_reg.gate ##1 s_reg.halted);

endmodule : sls_top

/* File: src/sls_defs.svh */
`ifndef SLS_DEFS_SVH
`define SLS_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define SLS_OFF_CTRL 8'h00
`define SLS_OFF_STATUS 8'h04
`define SLS_OFF_OPERAND 8'h08
`define SLS_OFF_STACK 8'h0C
`define SLS_OFF_ENTRY 8'h10
`define SLS_OFF_VMCR 8'h14
`define SLS_OFF_PEND 8'h18

// Control register fields
`define SLS_CTRL_START 0
`define SLS_CTRL_MP_EN 1
`define SLS_CTRL_GATE_SET 2

// Virtualisation control register fields
`define SLS_VMCR_DEBUG_DISABLE 0
`define SLS_VMCR_INIT_REDIRECT 1
`define SLS_VMCR_A20_MASK_DISABLE 2
`define SLS_VMCR_ALL_SET 3'h7

// Pending interrupt lanes
`define SLS_IRQ_DEV 0
`define SLS_IRQ_NMI 1
`define SLS_IRQ_SMI 2
`define SLS_IRQ_INIT 3

// Launch constants
`define SLS_CS_SELECTOR 16'h0008
`define SLS_SS_SELECTOR 16'h0010
`define SLS_SEG_BASE 32'h00000000
`define SLS_SEG_LIMIT 32'hFFFFFFFF
`define SLS_BLOCK_MASK 32'hFFFF0000
`define SLS_BLOCK_SIZE 32'h00010000
`define SLS_WORD_BYTES 32'h00000004

// Reset values
`define SLS_RST_WORD 32'h00000000
`define SLS_RST_GATE 1'b1

`endif

/* File: src/sls_pkg.sv */
package sls_pkg;

	// Launch sequencer states
	typedef enum logic [3:0] {
		SLS_IDLE = 4'h0,
		SLS_REINIT = 4'h1,
		SLS_GUARD = 4'h2,
		SLS_SHAKE = 4'h3,
		SLS_FETCH = 4'h4,
		SLS_SEND = 4'h5,
		SLS_HASH = 4'h6,
		SLS_MASK = 4'h7,
		SLS_STACK = 4'h8,
		SLS_JUMP = 4'h9
	} sls_state_t;

	// Transaction kinds toward the trusted module, unique to the launch
	typedef enum logic [1:0] {
		SLS_TK_NONE = 2'h0,
		SLS_TK_IMAGE = 2'h1,
		SLS_TK_HASH_END = 2'h2
	} sls_tkind_t;

	// Processor state imposed by the launch
	typedef struct packed {
		logic [15:0] cs_sel;
		logic [15:0] ss_sel;
		logic cs_readonly;
		logic ss_rw_expand_up;
		logic [31:0] seg_base;
		logic [31:0] seg_limit;
		logic prot_mode;
		logic paging_en;
		logic data_seg_real16;
		logic gpr_clear;
		logic extended_features_register_clear;
		logic prot_msr_clear;
	} sls_arch_t;

	// Stream toward the trusted module through the I/O hub
	typedef struct packed {
		logic valid;
		sls_tkind_t kind;
		logic [31:0] data;
	} sls_tpm_t;

	// Image memory read request
	typedef struct packed {
		logic rd;
		logic [31:0] addr;
	} sls_mem_t;

	// Complete state of the sequencer
	typedef struct packed {
		sls_state_t st;
		logic wait_reg;
		logic [31:0] rdata;
		logic [31:0] operand;
		logic [31:0] stack_pointer_register;
		logic [31:0] eip;
		logic [15:0] entry;
		logic [14:0] nwords;
		logic [14:0] idx;
		logic mp_en;
		logic [2:0] vmcr;
		logic debug_en;
		logic gate;
		logic guard_en;
		logic halted;
		logic done;
		logic jump;
		logic trap_block;
		logic ipi_req;
		logic [3:0] pend;
		logic [3:0] deliver;
		logic [3:0] irq_s1;
		logic [3:0] irq_s2;
		logic [1:0] ack_s;
		logic [1:0] shut_s;
		sls_arch_t arch;
		sls_mem_t mem;
		sls_tpm_t tpm;
	} sls_regs_t;

endpackage : sls_pkg

/* File: tb/sls_far_model.sv */
`timescale 1ns/1ps
module sls_far_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Image memory side
	input wire sls_pkg::sls_mem_t i_mem,
	output logic o_mem_valid,
	output logic [31:0] o_mem_rdata,
	// Trusted module side
	input wire sls_pkg::sls_tpm_t i_tpm,
	output logic o_tpm_ready,
	// Bench control
	input wire logic i_stall,
	input wire logic i_clear,
	input wire logic [31:0] i_base,
	input wire logic [15:0] i_entry,
	input wire logic [15:0] i_len,
	// Observations
	output logic [15:0] o_nwords,
	output logic o_hash_end,
	output logic o_bad
);
	import sls_pkg::*;

	// Header word at block offset zero, filler words elsewhere
	function automatic logic [31:0] img_word(input logic [31:0] a);
		img_word = (a[15:0] == 16'h0000) ? {i_len, i_entry} : ~a;
	endfunction : img_word

	// Memory answers late when stalled; trusted module records the stream
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_valid <= 1'b0;
			o_mem_rdata <= 32'h00000000;
			o_tpm_ready <= 1'b0;
			o_nwords <= 16'h0000;
			o_hash_end <= 1'b0;
			o_bad <= 1'b0;
		end else begin
			o_mem_valid <= i_mem.rd && !o_mem_valid && !i_stall;
			// Released data lines show the inverse so stale data never matches
			o_mem_rdata <= (i_mem.rd && !o_mem_valid && !i_stall) ? img_word(i_mem.addr) : ~o_mem_rdata;
			o_tpm_ready <= !i_stall;
			if (i_clear) begin
				o_nwords <= 16'h0000;
				o_hash_end <= 1'b0;
				o_bad <= 1'b0;
			end else if (i_tpm.valid && o_tpm_ready) begin
				if (i_tpm.kind == SLS_TK_IMAGE) begin
					if (i_tpm.data !== img_word(i_base + {14'h0000, o_nwords, 2'b00})) o_bad <= 1'b1;
					if (o_hash_end) o_bad <= 1'b1;
					o_nwords <= o_nwords + 16'h0001;
				end else if (i_tpm.kind == SLS_TK_HASH_END) begin
					o_hash_end <= 1'b1;
					// Launch counts as invalid if nothing was hashed first
					if (o_nwords == 16'h0000 || o_hash_end) o_bad <= 1'b1;
				end else begin
					o_bad <= 1'b1;
				end
			end
		end
	end
endmodule : sls_far_model

/* File: tb/sls_top_tb.sv */
`timescale 1ns/1ps
`include "sls_defs.svh"
module sls_top_tb;
	import sls_pkg::*;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [7:0] i_avs_address = 8'h00;
	logic [31:0] i_avs_writedata = 32'h00000000, o_avs_readdata, o_operand, o_stack_ptr;
	logic [31:0] o_entry_addr, o_guard_base, mem_rdata, base = 32'h00000000, q;
	logic o_avs_waitrequest, mem_valid, tpm_ready, o_ipi_req, i_ipi_ack = 1'b0, i_shutdown = 1'b0;
	logic [3:0] i_irq = 4'h0, o_irq_deliver, got_irq = 4'h0;
	logic o_jump, o_guard_en, o_gate, o_trap_block, o_debug_en, o_halted, hash_end, bad;
	logic stall = 1'b0, clear = 1'b0, ord_bad = 1'b0;
	logic [15:0] entry = 16'h0000, ilen = 16'h0000, nwords;
	logic [15:0] lens [5] = '{16'h0000, 16'h0003, 16'h0004, 16'h0005, 16'h0800};
	sls_mem_t o_mem;
	sls_tpm_t o_tpm;
	sls_arch_t o_arch;
	int err_total = 0, n_compared = 0, n_jump = 0, n_clr = 0, j0, i;
	int seed = 32'h9803, seed_b = 32'h9803;

	sls_top DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_mem(o_mem),
		.i_mem_valid(mem_valid), .i_mem_rdata(mem_rdata), .o_tpm(o_tpm), .i_tpm_ready(tpm_ready),
		.o_ipi_req(o_ipi_req), .i_ipi_ack(i_ipi_ack), .i_irq(i_irq), .i_shutdown(i_shutdown),
		.o_irq_deliver(o_irq_deliver), .o_arch(o_arch), .o_operand(o_operand),
		.o_stack_ptr(o_stack_ptr), .o_entry_addr(o_entry_addr), .o_jump(o_jump),
		.o_guard_en(o_guard_en), .o_guard_base(o_guard_base), .o_gate(o_gate),
		.o_trap_block(o_trap_block), .o_debug_en(o_debug_en), .o_halted(o_halted));

	sls_far_model far (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mem(o_mem), .o_mem_valid(mem_valid),
		.o_mem_rdata(mem_rdata), .i_tpm(o_tpm), .o_tpm_ready(tpm_ready), .i_stall(stall),
		.i_clear(clear), .i_base(base), .i_entry(entry), .i_len(ilen), .o_nwords(nwords),
		.o_hash_end(hash_end), .o_bad(bad));

	// Clock and watchdog; a hang counts as a mismatch
	always #2.5 i_ref_clk = ~i_ref_clk;
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end

	// Monitors, handshake echo and random stalls of the far side
	always @(posedge i_ref_clk) begin
		if (o_jump === 1'b1) n_jump <= n_jump + 1;
		if (o_arch.gpr_clear === 1'b1 && o_arch.extended_features_register_clear === 1'b1) n_clr <= n_clr + 1;
		// Launch start clears the observations here, so each has one driver
		if (clear) begin
			got_irq <= 4'h0;
			ord_bad <= 1'b0;
		end else begin
			if (o_irq_deliver !== 4'h0) got_irq <= got_irq | o_irq_deliver;
			if (o_ipi_req === 1'b1 && nwords !== 16'h0000) ord_bad <= 1'b1;
			if (o_tpm.valid === 1'b1 && o_trap_block !== 1'b1) ord_bad <= 1'b1;
		end
		i_ipi_ack <= o_ipi_req;
		stall <= ($random(seed_b) & 3) == 0;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon access; request held until waitrequest is seen low
	task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_writedata <= d;
		@(posedge i_ref_clk);
		while (o_avs_waitrequest !== 1'b0 && n < 100) begin
			@(posedge i_ref_clk);
			n++;
		end
		// Read data taken at the very edge that sees waitrequest low
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		chk(32'(n < 100), 32'h1);
		@(posedge i_ref_clk);
	endtask : av

	task do_reset();
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		chk(32'({o_gate, o_debug_en, o_halted, o_guard_en}), 32'hC);
		av(1'b0, `SLS_OFF_STATUS, 32'h0);
		chk(q, 32'h00000002);
		av(1'b0, `SLS_OFF_VMCR, 32'h0);
		chk(q, 32'h00000000);
	endtask : do_reset

	// Full launch with interrupts raised while it runs
	task launch(input logic [31:0] op, input logic [15:0] len, input logic mp, input logic [3:0] ln);
		int n, c0;
		n = 0;
		base <= op & 32'hFFFF0000;
		entry <= 16'($random(seed));
		ilen <= len;
		clear <= 1'b1;
		@(posedge i_ref_clk);
		clear <= 1'b0;
		c0 = n_clr;
		av(1'b1, `SLS_OFF_OPERAND, op);
		av(1'b1, `SLS_OFF_CTRL, {29'h0, 1'b0, mp, 1'b1});
		i_irq <= ln;
		while (o_jump !== 1'b1 && n < 30000) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk(32'(o_jump), 32'h1);
		chk(o_entry_addr, base + {16'h0000, entry});
		chk(o_stack_ptr, base + 32'h00010000);
		chk(o_operand, base);
		chk(o_guard_base, base);
		chk(32'({o_guard_en, o_gate, o_trap_block}), 32'h4);
		chk({o_arch.cs_sel, o_arch.ss_sel}, 32'h00080010);
		chk(o_arch.seg_base, 32'h00000000);
		chk(o_arch.seg_limit, 32'hFFFFFFFF);
		chk(32'({o_arch.cs_readonly, o_arch.ss_rw_expand_up, o_arch.prot_mode,
			o_arch.paging_en, o_arch.data_seg_real16}), 32'h1D);
		@(posedge i_ref_clk);
		i_irq <= 4'h0;
		repeat (10) @(posedge i_ref_clk);
		chk(32'(n_clr - c0), 32'h1);
		chk(32'(nwords), (len == 16'h0) ? 32'h1 : (32'(len) + 32'h3) >> 2);
		chk(32'({hash_end, bad, ord_bad}), 32'h4);
		chk(32'(got_irq), 32'h0);
		av(1'b0, `SLS_OFF_PEND, 32'h0);
		chk(q, 32'(ln));
		av(1'b0, `SLS_OFF_VMCR, 32'h0);
		chk(q, 32'h00000007);
		chk(32'(o_debug_en), 32'h0);
	endtask : launch

	// Software sets the gate and re-enables debug after the loader starts
	task unlock(input logic [3:0] ln);
		av(1'b1, `SLS_OFF_CTRL, 32'h00000004);
		repeat (10) @(posedge i_ref_clk);
		chk(32'({got_irq, o_gate}), 32'({ln, 1'b1}));
		av(1'b1, `SLS_OFF_VMCR, 32'h00000000);
		chk(32'(o_debug_en), 32'h1);
	endtask : unlock

	task print_verdict();
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		logic [3:0] ln;
		do_reset();
		av(1'b0, 8'h1C, 32'h0);
		chk(q, 32'h00000000);
		for (i = 0; i < 7; i++) begin
			ln = 4'($random(seed));
			launch($random(seed), (i < 5) ? lens[i] : 16'($random(seed) & 16'h01FF), i[0], ln);
			if (i < 6) unlock(ln);
		end
		// Shutdown while the gate is clear: only reset revives it
		i_shutdown <= 1'b1;
		repeat (5) @(posedge i_ref_clk);
		chk(32'(o_halted), 32'h1);
		j0 = n_jump;
		av(1'b1, `SLS_OFF_CTRL, 32'h00000001);
		repeat (40) @(posedge i_ref_clk);
		chk(32'(n_jump - j0), 32'h0);
		i_shutdown <= 1'b0;
		do_reset();
		print_verdict();
	end
endmodule : sls_top_tb
